// ### logic/data_move_decoder.sv
// Decode and sequencing of the byte and bit data move instructions
`timescale 1ns/1ps

// Notes on behaviour
// - Register to direct: two bytes, two cycles
// - Direct to direct: three bytes, two cycles
// - Indirect RAM to direct: two bytes, two cycles
// - Immediate to direct: three bytes, two cycles
// - Direct to indirect RAM: two bytes, two cycles
// - Immediate to indirect RAM: two bytes, one cycle
// - Bit move copies source bit into destination
// - Bit moves always involve the carry flag
// - Bit move changes only its destination bit
// - Bit to carry: two bytes, one cycle
// - Carry to bit: two bytes, two cycles
module data_move_decoder (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Instruction from the fetch unit
    input wire logic start_in,
    input wire logic [7:0] opcode_in,
    input wire logic [7:0] operand1_in,
    input wire logic [7:0] operand2_in,
    input wire logic [1:0] bank_in,
    output logic busy_out,
    output logic done_out,
    output logic illegal_out,
    output logic [1:0] length_out,
    output logic [1:0] cycles_out,
    // Working register read port
    output logic reg_en_out,
    output logic [4:0] reg_addr_out,
    input wire logic [7:0] reg_data_in,
    // Data read port
    output logic rd_en_out,
    output logic [1:0] rd_kind_out,
    output logic [7:0] rd_addr_out,
    input wire logic [7:0] rd_data_in,
    // Data write port
    output logic wr_en_out,
    output logic [1:0] wr_kind_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    // Carry flag
    input wire logic carry_in,
    output logic carry_we_out,
    output logic carry_out
);

    // All sequencer state in one word
    typedef struct packed {
        data_move_pkg::state_e st;  // Sequencer phase
        data_move_pkg::op_e op;     // Form being executed
        logic two;                  // Two machine cycles
        logic [1:0] len;            // Byte length of the form
        logic illegal;              // Unknown opcode pulse
        logic reg_en;               // Working register read
        logic [4:0] reg_addr;       // Bank and register
        logic rd_en;                // Data read
        logic [1:0] rd_kind;
        logic [7:0] rd_addr;
        logic [1:0] wr_kind;        // Destination space
        logic [7:0] wr_addr;        // Destination address
        logic [7:0] wr_data;        // Byte or bit to store
    } seq_s;

    seq_s s_r;   // Registered state
    seq_s s_nxt; // Next state

    // Decoded form of the opcode on the fetch bus
    data_move_pkg::op_e dec_op;
    assign dec_op = data_move_pkg::op_decode(opcode_in);

    // Next state: accept, read, capture, write
    always_comb begin
        s_nxt = s_r;
        s_nxt.illegal = 1'b0;
        s_nxt.rd_en = 1'b0;
        s_nxt.reg_en = 1'b0;
        case (s_r.st)
            data_move_pkg::ST_IDLE: begin
                // Accept only while idle; the fetch unit waits on busy
                if (start_in && dec_op == data_move_pkg::OP_NONE) begin
                    s_nxt.illegal = 1'b1;
                end else if (start_in) begin
                    s_nxt.st = data_move_pkg::ST_FIRST;
                    s_nxt.op = dec_op;
                    s_nxt.two = data_move_pkg::op_cycles(dec_op) == data_move_pkg::CYC_2;
                    s_nxt.len = data_move_pkg::op_bytes(dec_op);
                    // Defaults: direct destination in the second byte
                    s_nxt.wr_kind = data_move_pkg::KIND_DIR;
                    s_nxt.wr_addr = operand1_in;
                    s_nxt.wr_data = 8'h00;
                    s_nxt.rd_kind = data_move_pkg::KIND_DIR;
                    s_nxt.rd_addr = operand1_in;
                    // Pointer is the first or second register of the bank
                    s_nxt.reg_addr = {bank_in, data_move_pkg::PTR_HIGH_BITS, opcode_in[0]};
                    case (dec_op)
                        data_move_pkg::OP_RN_DIR: begin
                            s_nxt.reg_en = 1'b1;
                            s_nxt.reg_addr = {bank_in, opcode_in[2:0]};
                        end
                        data_move_pkg::OP_DIR_DIR: begin
                            s_nxt.rd_en = 1'b1;
                            s_nxt.wr_addr = operand2_in;
                        end
                        data_move_pkg::OP_IND_DIR: begin
                            s_nxt.reg_en = 1'b1;
                        end
                        data_move_pkg::OP_IMM_DIR: begin
                            s_nxt.wr_data = operand2_in;
                        end
                        data_move_pkg::OP_DIR_IND: begin
                            s_nxt.rd_en = 1'b1;
                            s_nxt.reg_en = 1'b1;
                            s_nxt.wr_kind = data_move_pkg::KIND_IND;
                        end
                        data_move_pkg::OP_IMM_IND: begin
                            s_nxt.reg_en = 1'b1;
                            s_nxt.wr_kind = data_move_pkg::KIND_IND;
                            s_nxt.wr_data = operand1_in;
                        end
                        data_move_pkg::OP_BIT_C: begin
                            s_nxt.rd_en = 1'b1;
                            s_nxt.rd_kind = data_move_pkg::KIND_BIT;
                        end
                        data_move_pkg::OP_C_BIT: begin
                            s_nxt.wr_kind = data_move_pkg::KIND_BIT;
                        end
                        default: begin
                            s_nxt.st = data_move_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            data_move_pkg::ST_FIRST: begin
                // Read data arrives in the same cycle as its address
                s_nxt.st = s_r.two ? data_move_pkg::ST_SECOND : data_move_pkg::ST_FINISH;
                case (s_r.op)
                    data_move_pkg::OP_RN_DIR: s_nxt.wr_data = reg_data_in;
                    data_move_pkg::OP_DIR_DIR: s_nxt.wr_data = rd_data_in;
                    data_move_pkg::OP_IND_DIR: begin
                        // Pointer now known, fetch the RAM byte next
                        s_nxt.rd_en = 1'b1;
                        s_nxt.rd_kind = data_move_pkg::KIND_IND;
                        s_nxt.rd_addr = reg_data_in;
                    end
                    data_move_pkg::OP_DIR_IND: begin
                        s_nxt.wr_data = rd_data_in;
                        s_nxt.wr_addr = reg_data_in;
                    end
                    data_move_pkg::OP_IMM_IND: s_nxt.wr_addr = reg_data_in;
                    data_move_pkg::OP_BIT_C: begin
                        s_nxt.wr_data = {7'h00, rd_data_in[0]};
                    end
                    data_move_pkg::OP_C_BIT: begin
                        s_nxt.wr_data = {7'h00, carry_in};
                    end
                    default: begin
                        s_nxt.wr_data = s_r.wr_data;
                    end
                endcase
            end
            data_move_pkg::ST_SECOND: begin
                s_nxt.st = data_move_pkg::ST_FINISH;
                if (s_r.op == data_move_pkg::OP_IND_DIR) begin
                    s_nxt.wr_data = rd_data_in;
                end
            end
            data_move_pkg::ST_FINISH: begin
                // Write strobes stand for this one cycle only
                s_nxt.st = data_move_pkg::ST_IDLE;
            end
            default: begin
                s_nxt.st = data_move_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Status toward fetch
    assign busy_out = s_r.st != data_move_pkg::ST_IDLE;
    assign done_out = s_r.st == data_move_pkg::ST_FINISH;
    assign illegal_out = s_r.illegal;
    assign length_out = s_r.len;
    assign cycles_out = data_move_pkg::op_cycles(s_r.op);

    // Read ports straight from the state word
    assign reg_en_out = s_r.reg_en;
    assign reg_addr_out = s_r.reg_addr;
    assign rd_en_out = s_r.rd_en;
    assign rd_kind_out = s_r.rd_kind;
    assign rd_addr_out = s_r.rd_addr;

    // Exactly one destination is written per move
    assign wr_en_out = done_out && s_r.op != data_move_pkg::OP_BIT_C;
    assign carry_we_out = done_out && s_r.op == data_move_pkg::OP_BIT_C;
    assign wr_kind_out = s_r.wr_kind;
    assign wr_addr_out = s_r.wr_addr;
    assign wr_data_out = s_r.wr_data;
    assign carry_out = s_r.wr_data[0];

    // Accepted instruction, helper for the checks below
    logic acc;
    assign acc = start_in && !busy_out;

    // Checks share the core clock and stand down while reset is held
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    property p_rn_dir;
        acc && opcode_in[7:3] == data_move_pkg::PFX_RN_DIR |=>
            reg_en_out && reg_addr_out == {$past(bank_in), $past(opcode_in[2:0])}
            ##2 wr_en_out && wr_kind_out == data_move_pkg::KIND_DIR
            && wr_addr_out == $past(operand1_in, 3);
    endproperty
    a_rn_dir: assert property (p_rn_dir) else $error("register to direct wrong");

    property p_dir_dir;
        acc && opcode_in == data_move_pkg::OPC_DIR_DIR |=>
            rd_en_out && rd_addr_out == $past(operand1_in)
            ##2 wr_en_out && wr_addr_out == $past(operand2_in, 3);
    endproperty
    a_dir_dir: assert property (p_dir_dir) else $error("direct to direct wrong");

    property p_ind_dir;
        acc && opcode_in[7:1] == data_move_pkg::PFX_IND_DIR |=>
            reg_addr_out[0] == $past(opcode_in[0])
            ##1 rd_en_out && rd_kind_out == data_move_pkg::KIND_IND
            && rd_addr_out == $past(reg_data_in)
            ##1 wr_en_out && wr_data_out == $past(rd_data_in);
    endproperty
    a_ind_dir: assert property (p_ind_dir) else $error("indirect to direct wrong");

    property p_imm_dir;
        acc && opcode_in == data_move_pkg::OPC_IMM_DIR |->
            ##3 wr_en_out && wr_data_out == $past(operand2_in, 3) && length_out == 2'h3;
    endproperty
    a_imm_dir: assert property (p_imm_dir) else $error("immediate to direct wrong");

    property p_dir_ind;
        acc && opcode_in[7:1] == data_move_pkg::PFX_DIR_IND |->
            ##3 wr_en_out && wr_kind_out == data_move_pkg::KIND_IND
            && wr_addr_out == $past(reg_data_in, 2);
    endproperty
    a_dir_ind: assert property (p_dir_ind) else $error("direct to indirect wrong");

    property p_imm_ind;
        acc && opcode_in[7:1] == data_move_pkg::PFX_IMM_IND |->
            ##2 done_out && wr_kind_out == data_move_pkg::KIND_IND
            && wr_data_out == $past(operand1_in, 2);
    endproperty
    a_imm_ind: assert property (p_imm_ind) else $error("immediate to indirect wrong");

    property p_bit_c;
        acc && opcode_in == data_move_pkg::OPC_BIT_C |->
            ##2 carry_we_out && carry_out == $past(rd_data_in[0]) && !wr_en_out;
    endproperty
    a_bit_c: assert property (p_bit_c) else $error("bit to carry wrong");

    property p_c_bit;
        acc && opcode_in == data_move_pkg::OPC_C_BIT |->
            ##3 wr_en_out && wr_kind_out == data_move_pkg::KIND_BIT
            && wr_data_out[0] == $past(carry_in, 2) && !carry_we_out;
    endproperty
    a_c_bit: assert property (p_c_bit) else $error("carry to bit wrong");

    property p_bit_read;
        rd_en_out && rd_kind_out == data_move_pkg::KIND_BIT |=> carry_we_out;
    endproperty
    a_bit_read: assert property (p_bit_read) else $error("bit read not to carry");

    property p_one_dest;
        wr_en_out || carry_we_out |-> $past(busy_out) && !(wr_en_out && carry_we_out);
    endproperty
    a_one_dest: assert property (p_one_dest) else $error("stray write");

    // Unknown opcode: one pulse, and only as the answer to a start while idle
    property p_illegal;
        illegal_out |-> !busy_out && $past(start_in) && !$past(busy_out);
    endproperty
    a_illegal: assert property (p_illegal) else $error("stray illegal pulse");

    // A start in the done cycle is refused, so the sequencer goes idle
    property p_refuse;
        start_in && done_out |=> !busy_out && !illegal_out && !rd_en_out && !reg_en_out;
    endproperty
    a_refuse: assert property (p_refuse) else $error("start taken in done cycle");

    // Main scenarios: a three byte move, a one cycle store, a carry load, a reject
    c_two_cycle: cover property (acc && opcode_in == data_move_pkg::OPC_DIR_DIR ##3 done_out);
    c_imm_ind: cover property (acc && opcode_in[7:1] == data_move_pkg::PFX_IMM_IND ##2 done_out);
    c_bit_c: cover property (carry_we_out);
    c_illegal: cover property (illegal_out);

endmodule : data_move_decoder

// ### logic/data_move_pkg.sv
// Constants, encodings and decode helpers for the data move decoder
package data_move_pkg;

    // Fixed opcodes and opcode prefixes of the move family
    localparam logic [4:0] PFX_RN_DIR = 5'h11;  // Work register to direct, low 3 bits select
    localparam logic [7:0] OPC_DIR_DIR = 8'h85; // Direct to direct
    localparam logic [6:0] PFX_IND_DIR = 7'h43; // Indirect RAM to direct, low bit picks pointer
    localparam logic [7:0] OPC_IMM_DIR = 8'h75; // Immediate to direct
    localparam logic [6:0] PFX_DIR_IND = 7'h53; // Direct to indirect RAM
    localparam logic [6:0] PFX_IMM_IND = 7'h3B; // Immediate to indirect RAM
    localparam logic [7:0] OPC_BIT_C = 8'hA3;   // Addressed bit to carry
    localparam logic [7:0] OPC_C_BIT = 8'h92;   // Carry to addressed bit

    // Instruction lengths in bytes and machine cycle counts
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [1:0] CYC_1 = 2'h1;
    localparam logic [1:0] CYC_2 = 2'h2;

    // Address space codes for the read and write ports
    localparam logic [1:0] KIND_DIR = 2'h0; // Directly addressed byte
    localparam logic [1:0] KIND_IND = 2'h1; // Internal RAM through a pointer
    localparam logic [1:0] KIND_BIT = 2'h2; // Directly addressable bit, value in bit 0

    // Pointer registers sit at the bottom of the active bank
    localparam logic [1:0] PTR_HIGH_BITS = 2'h0;

    // Decoded instruction forms
    typedef enum logic [3:0] {
        OP_NONE, OP_RN_DIR, OP_DIR_DIR, OP_IND_DIR, OP_IMM_DIR,
        OP_DIR_IND, OP_IMM_IND, OP_BIT_C, OP_C_BIT
    } op_e;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE, ST_FIRST, ST_SECOND, ST_FINISH
    } state_e;

    // Opcode to instruction form
    function automatic op_e op_decode(input logic [7:0] opc);
        op_e r;
        r = OP_NONE;
        if (opc[7:3] == PFX_RN_DIR) r = OP_RN_DIR;
        else if (opc == OPC_DIR_DIR) r = OP_DIR_DIR;
        else if (opc[7:1] == PFX_IND_DIR) r = OP_IND_DIR;
        else if (opc == OPC_IMM_DIR) r = OP_IMM_DIR;
        else if (opc[7:1] == PFX_DIR_IND) r = OP_DIR_IND;
        else if (opc[7:1] == PFX_IMM_IND) r = OP_IMM_IND;
        else if (opc == OPC_BIT_C) r = OP_BIT_C;
        else if (opc == OPC_C_BIT) r = OP_C_BIT;
        return r;
    endfunction : op_decode

    // Machine cycles per form
    function automatic logic [1:0] op_cycles(input op_e op);
        return (op == OP_IMM_IND || op == OP_BIT_C) ? CYC_1 : CYC_2;
    endfunction : op_cycles

    // Bytes per form
    function automatic logic [1:0] op_bytes(input op_e op);
        return (op == OP_DIR_DIR || op == OP_IMM_DIR) ? LEN_3 : LEN_2;
    endfunction : op_bytes

endpackage : data_move_pkg

// ### verification/data_move_decoder_test.sv
// Self-checking testbench for the data move decoder
`timescale 1ns/1ps
module data_move_decoder_test;
    // Stimulus into the decoder, all given a value at time zero
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic start_in = 1'b0;
    logic [7:0] opcode_in = 8'h00;
    logic [7:0] operand1_in = 8'h00;
    logic [7:0] operand2_in = 8'h00;
    logic [1:0] bank_in = 2'h0;
    logic [7:0] reg_data_in = 8'h00;
    logic [7:0] rd_data_in = 8'h00;
    logic carry_in = 1'b0;
    // Decoder outputs
    logic busy_out, done_out, illegal_out, reg_en_out, rd_en_out, wr_en_out, carry_we_out;
    logic carry_out;
    logic [1:0] length_out, cycles_out, rd_kind_out, wr_kind_out;
    logic [4:0] reg_addr_out;
    logic [7:0] rd_addr_out, wr_addr_out, wr_data_out;
    // Verdict counters and hang guard
    int n_fail = 0;
    int checked = 0;
    int ticks = 0;
    // Strobe tallies within one move, cleared as each move is offered
    int n_cyc, n_wr, n_cwe, n_rd, n_reg;
    logic busy1;
    logic [7:0] rd_a;
    logic [1:0] rd_k;
    logic [4:0] reg_a;

    data_move_decoder u_data_move_decoder (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .start_in(start_in),
        .opcode_in(opcode_in), .operand1_in(operand1_in), .operand2_in(operand2_in),
        .bank_in(bank_in), .busy_out(busy_out), .done_out(done_out),
        .illegal_out(illegal_out), .length_out(length_out), .cycles_out(cycles_out),
        .reg_en_out(reg_en_out), .reg_addr_out(reg_addr_out), .reg_data_in(reg_data_in),
        .rd_en_out(rd_en_out), .rd_kind_out(rd_kind_out), .rd_addr_out(rd_addr_out),
        .rd_data_in(rd_data_in), .wr_en_out(wr_en_out), .wr_kind_out(wr_kind_out),
        .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .carry_in(carry_in),
        .carry_we_out(carry_we_out), .carry_out(carry_out)
    );

    // Free-running 20 MHz clock
    initial begin
        forever #25 clock_in = ~clock_in;
    end

    // Verdict and end of run
    task automatic close_out();
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // Single compare for every kind of result, widened to a byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Strobe tally at each edge; samples settled values, so no race with the design
    always @(posedge clock_in) begin
        ticks <= ticks + 1;
        // Whole run is under a hundred cycles, so this only trips on a hang
        if (ticks == 3000) begin
            n_fail++;
            close_out();
        end
        if (wr_en_out === 1'b1) n_wr <= n_wr + 1;
        if (carry_we_out === 1'b1) n_cwe <= n_cwe + 1;
        if (reg_en_out === 1'b1) begin
            n_reg <= n_reg + 1;
            reg_a <= reg_addr_out;
        end
        if (rd_en_out === 1'b1) begin
            n_rd <= n_rd + 1;
            rd_a <= rd_addr_out;
            rd_k <= rd_kind_out;
        end
    end

    // Offer one move for one cycle, then step until done or a bound
    task automatic issue(input logic [7:0] opc, input logic [7:0] op1, input logic [7:0] op2,
                         input logic [1:0] bank, input logic [7:0] regv,
                         input logic [7:0] rdv, input logic c);
        @(posedge clock_in);
        start_in <= 1'b1;
        opcode_in <= opc;
        operand1_in <= op1;
        operand2_in <= op2;
        bank_in <= bank;
        reg_data_in <= regv;
        rd_data_in <= rdv;
        carry_in <= c;
        #1;
        n_wr = 0;
        n_cwe = 0;
        n_rd = 0;
        n_reg = 0;
        @(posedge clock_in);
        start_in <= 1'b0;
        #1;
        busy1 = busy_out;
        n_cyc = 1;
        while (done_out !== 1'b1 && n_cyc < 8) begin
            @(posedge clock_in);
            #1;
            n_cyc++;
        end
    endtask : issue

    // Timing and size of the finished move; nothing written before the done cycle
    task automatic tail(input int cyc, input logic [7:0] len);
        chk({7'h00, busy1}, 8'h01);
        chk(n_cyc[7:0], cyc[7:0] + 8'h01);
        chk({6'h00, length_out}, len);
        chk({6'h00, cycles_out}, cyc[7:0]);
        chk(n_wr[7:0], 8'h00);
        chk(n_cwe[7:0], 8'h00);
    endtask : tail

    // Byte or bit destination written in the done cycle
    task automatic fin(input int cyc, input logic [7:0] len, input logic [7:0] kind,
                       input logic [7:0] addr, input logic [7:0] data);
        tail(cyc, len);
        chk({7'h00, wr_en_out}, 8'h01);
        chk({7'h00, carry_we_out}, 8'h00);
        chk({6'h00, wr_kind_out}, kind);
        chk(wr_addr_out, addr);
        chk(wr_data_out, data);
    endtask : fin

    // All eight working registers, in a bank other than zero
    task automatic t_rn_dir();
        for (int r = 0; r < 8; r++) begin
            issue(8'h88 + r[7:0], 8'h31, 8'h00, 2'h2, 8'hC0 + r[7:0], 8'h5A, 1'b0);
            chk({3'h0, reg_a}, {3'h0, 2'h2, r[2:0]});
            chk(n_rd[7:0], 8'h00);
            fin(2, 8'h02, 8'h00, 8'h31, 8'hC0 + r[7:0]);
        end
    endtask : t_rn_dir

    // Source from the second byte, destination from the third
    task automatic t_dir_dir();
        issue(8'h85, 8'h30, 8'h47, 2'h1, 8'h11, 8'h9C, 1'b0);
        chk(rd_a, 8'h30);
        chk({6'h00, rd_k}, 8'h00);
        fin(2, 8'h03, 8'h00, 8'h47, 8'h9C);
    endtask : t_dir_dir

    // Both pointers, read through RAM, then byte to direct
    task automatic t_ind_dir();
        for (int i = 0; i < 2; i++) begin
            issue(8'h86 + i[7:0], 8'h52, 8'h00, 2'h3, 8'h6E, 8'hD3, 1'b0);
            chk({3'h0, reg_a}, {3'h0, 2'h3, 2'h0, i[0]});
            chk(rd_a, 8'h6E);
            chk({6'h00, rd_k}, 8'h01);
            fin(2, 8'h02, 8'h00, 8'h52, 8'hD3);
        end
    endtask : t_ind_dir

    // Address then immediate; no reads at all
    task automatic t_imm_dir();
        issue(8'h75, 8'h44, 8'hE1, 2'h0, 8'h12, 8'h34, 1'b0);
        chk(n_rd[7:0] + n_reg[7:0], 8'h00);
        fin(2, 8'h03, 8'h00, 8'h44, 8'hE1);
    endtask : t_imm_dir

    // Direct byte into RAM at either pointer
    task automatic t_dir_ind();
        for (int i = 0; i < 2; i++) begin
            issue(8'hA6 + i[7:0], 8'h25, 8'h00, 2'h1, 8'h7B, 8'h3F, 1'b0);
            chk({3'h0, reg_a}, {3'h0, 2'h1, 2'h0, i[0]});
            chk(rd_a, 8'h25);
            fin(2, 8'h02, 8'h01, 8'h7B, 8'h3F);
        end
    endtask : t_dir_ind

    // Immediate into RAM in a single cycle
    task automatic t_imm_ind();
        for (int i = 0; i < 2; i++) begin
            issue(8'h76 + i[7:0], 8'hB8, 8'h00, 2'h2, 8'h19, 8'h00, 1'b0);
            chk({3'h0, reg_a}, {3'h0, 2'h2, 2'h0, i[0]});
            chk(n_rd[7:0], 8'h00);
            fin(1, 8'h02, 8'h01, 8'h19, 8'hB8);
        end
    endtask : t_imm_ind

    // Bit into carry, old carry the opposite so a pass-through shows
    task automatic t_bit_c();
        logic b;
        for (int k = 0; k < 2; k++) begin
            b = k[0];
            issue(8'hA3, 8'h9B, 8'h00, 2'h0, 8'h00, {7'h52, b}, ~b);
            tail(1, 8'h02);
            chk({7'h00, carry_we_out}, 8'h01);
            chk({7'h00, carry_out}, {7'h00, b});
            chk({7'h00, wr_en_out}, 8'h00);
            chk(n_reg[7:0], 8'h00);
            chk(rd_a, 8'h9B);
            chk({6'h00, rd_k}, 8'h02);
        end
    endtask : t_bit_c

    // Carry into bit, read data the opposite so a wrong source shows
    task automatic t_c_bit();
        logic b;
        for (int k = 0; k < 2; k++) begin
            b = k[0];
            issue(8'h92, 8'hD5, 8'h00, 2'h0, 8'h00, {7'h2A, ~b}, b);
            chk(n_rd[7:0] + n_reg[7:0], 8'h00);
            fin(2, 8'h02, 8'h02, 8'hD5, {7'h00, b});
        end
    endtask : t_c_bit

    // Opcode next to bit-to-carry: one reject pulse, no move started
    task automatic t_illegal();
        @(posedge clock_in);
        start_in <= 1'b1;
        opcode_in <= 8'hA2;
        @(posedge clock_in);
        start_in <= 1'b0;
        #1;
        chk({7'h00, illegal_out}, 8'h01);
        chk({7'h00, busy_out}, 8'h00);
        @(posedge clock_in);
        #1;
        chk({7'h00, illegal_out}, 8'h00);
    endtask : t_illegal

    // Start held through a whole move, done cycle too; later offers are ignored
    task automatic t_refuse();
        @(posedge clock_in);
        start_in <= 1'b1;
        opcode_in <= 8'h75;
        operand1_in <= 8'h61;
        operand2_in <= 8'h0D;
        @(posedge clock_in);
        opcode_in <= 8'h85;
        operand1_in <= 8'h10;
        operand2_in <= 8'h20;
        repeat (2) @(posedge clock_in);
        #1;
        chk({7'h00, done_out}, 8'h01);
        chk(wr_addr_out, 8'h61);
        chk(wr_data_out, 8'h0D);
        @(posedge clock_in);
        start_in <= 1'b0;
        #1;
        chk({7'h00, busy_out}, 8'h00);
        chk({7'h00, rd_en_out}, 8'h00);
    endtask : t_refuse

    // Reset, then each scenario in turn
    initial begin
        repeat (4) @(posedge clock_in);
        rst_b_in <= 1'b1;
        t_rn_dir();
        t_dir_dir();
        t_ind_dir();
        t_imm_dir();
        t_dir_ind();
        t_imm_ind();
        t_bit_c();
        t_c_bit();
        t_illegal();
        t_refuse();
        close_out();
    end
endmodule : data_move_decoder_test
